// ### core/hpc_pkg.sv
// Constants for the hub port configuration register bank
package hpc_pkg;
	localparam logic [7:0] HPC_ADDR_BOOST = 8'hF8;
	localparam logic [7:0] HPC_ADDR_SWAP = 8'hFA;
	localparam logic [7:0] HPC_ADDR_REMAP = 8'hFB;
	localparam logic [7:0] HPC_RST_BOOST = 8'h00;
	localparam logic [7:0] HPC_RST_SWAP = 8'h00;
	localparam logic [7:0] HPC_RST_REMAP = 8'h21;
	localparam logic [7:0] HPC_MASK_BOOST = 8'h77;
	localparam logic [7:0] HPC_MASK_SWAP = 8'h0E;
	localparam int HPC_P2_BOOST_LSB = 4;
	localparam int HPC_P1_BOOST_LSB = 0;
	localparam int HPC_P2_MAP_LSB = 4;
	localparam int HPC_P1_MAP_LSB = 0;
	localparam logic [3:0] HPC_MAP_MAX = 4'h3;
	localparam logic [3:0] HPC_MAP_OFF = 4'h0;
	localparam logic [1:0] HPC_PORT_COUNT = 2'h3;
endpackage

// ### core/hpc_regs.sv
// Port configuration registers of the three-port hub
`timescale 1ns/100ps
module hpc_regs
	import hpc_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register access from the serial configuration port
	input wire logic wr_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// Mode control
	input wire logic remap_mode_enable_i,
	// Static settings to the hub core
	output logic [2:0] port1_drive_current_sel_o,
	output logic [2:0] port2_drive_current_sel_o,
	output logic [3:1] data_pin_swap_o,
	output logic [3:0] port1_logical_o,
	output logic [3:0] port2_logical_o,
	output logic [1:0] port_count_o
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [3:0] map_clean(input logic [3:0] code);
		if (code > HPC_MAP_MAX) begin
			return HPC_MAP_OFF;
		end
		return code;
	endfunction

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] boost;
	logic [7:0] swap;
	logic [7:0] remap;
	logic [7:0] next_boost;
	logic [7:0] next_swap;
	logic [7:0] next_remap;
	logic [7:0] next_rdata;
	logic [3:0] next_p1_log;
	logic [3:0] next_p2_log;

	always_comb begin
		next_boost = boost;
		next_swap = swap;
		next_remap = remap;
		if (wr_en_i) begin
			case (addr_i)
				HPC_ADDR_BOOST: next_boost = wdata_i & HPC_MASK_BOOST;
				HPC_ADDR_SWAP: next_swap = wdata_i & HPC_MASK_SWAP;
				HPC_ADDR_REMAP: begin
					next_remap = {map_clean(wdata_i[7:4]), map_clean(wdata_i[3:0])};
				end
				default: next_remap = remap;
			endcase
		end
		case (addr_i)
			HPC_ADDR_BOOST: next_rdata = next_boost;
			HPC_ADDR_SWAP: next_rdata = next_swap;
			HPC_ADDR_REMAP: next_rdata = next_remap;
			default: next_rdata = 8'h00;
		endcase
		// Default numbering unless remap mode is on
		if (remap_mode_enable_i) begin
			next_p2_log = next_remap[HPC_P2_MAP_LSB +: 4];
			next_p1_log = next_remap[HPC_P1_MAP_LSB +: 4];
		end else begin
			next_p2_log = HPC_RST_REMAP[HPC_P2_MAP_LSB +: 4];
			next_p1_log = HPC_RST_REMAP[HPC_P1_MAP_LSB +: 4];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			boost <= HPC_RST_BOOST;
			swap <= HPC_RST_SWAP;
			remap <= HPC_RST_REMAP;
			rdata_o <= 8'h00;
			port1_drive_current_sel_o <= 3'h0;
			port2_drive_current_sel_o <= 3'h0;
			data_pin_swap_o <= 3'h0;
			port1_logical_o <= HPC_RST_REMAP[HPC_P1_MAP_LSB +: 4];
			port2_logical_o <= HPC_RST_REMAP[HPC_P2_MAP_LSB +: 4];
			port_count_o <= HPC_PORT_COUNT;
		end else begin
			boost <= next_boost;
			swap <= next_swap;
			remap <= next_remap;
			rdata_o <= next_rdata;
			port2_drive_current_sel_o <= next_boost[HPC_P2_BOOST_LSB +: 3];
			port1_drive_current_sel_o <= next_boost[HPC_P1_BOOST_LSB +: 3];
			// Each of bits 3:1 exchanges positive and negative data pins of one port
			data_pin_swap_o <= next_swap[3:1];
			port1_logical_o <= next_p1_log;
			port2_logical_o <= next_p2_log;
			// Only the count is reported; host numbers from one
			port_count_o <= HPC_PORT_COUNT;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence remap_wr_bad_s;
		wr_en_i && addr_i == HPC_ADDR_REMAP && wdata_i[3:0] > HPC_MAP_MAX;
	endsequence

	sequence remap_wr_hi_bad_s;
		wr_en_i && addr_i == HPC_ADDR_REMAP && wdata_i[7:4] > HPC_MAP_MAX;
	endsequence

	sequence remap_wr_s;
		wr_en_i && addr_i == HPC_ADDR_REMAP;
	endsequence

	sequence remap_wr_on_s;
		remap_mode_enable_i && wr_en_i && addr_i == HPC_ADDR_REMAP;
	endsequence

	sequence remap_rd_s;
		!wr_en_i && addr_i == HPC_ADDR_REMAP;
	endsequence

	sequence boost_wr_s;
		wr_en_i && addr_i == HPC_ADDR_BOOST;
	endsequence

	sequence swap_wr_s;
		wr_en_i && addr_i == HPC_ADDR_SWAP;
	endsequence

	// Reserved codes must never reach the hub core as a live port number
	remap_clamp_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_bad_s |=> remap[3:0] == 4'h0)
		else $error("bad remap code not cleared");

	remap_hi_clamp_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_hi_bad_s |=> remap[7:4] == 4'h0)
		else $error("bad high remap code not cleared");

	remap_lo_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_s ##0 wdata_i[3:0] <= HPC_MAP_MAX |=> remap[3:0] == $past(wdata_i[3:0]))
		else $error("good port one code lost");

	remap_hi_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_s ##0 wdata_i[7:4] <= HPC_MAP_MAX |=> remap[7:4] == $past(wdata_i[7:4]))
		else $error("good port two code lost");

	remap_reset_a: assert property (@(posedge mclk_i)
		!rst_n_i |=> remap == 8'h21)
		else $error("remap not 0x21 after reset");

	boost_resv_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		boost[7] == 1'b0 && boost[3] == 1'b0)
		else $error("boost reserved bit set");

	boost_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		wr_en_i && addr_i == HPC_ADDR_BOOST |=> port2_drive_current_sel_o == $past(wdata_i[6:4]))
		else $error("port two drive code wrong");

	boost_p1_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		boost_wr_s |=> port1_drive_current_sel_o == $past(wdata_i[2:0]))
		else $error("port one drive code wrong");

	// Drive settings are static: only a write may move them
	boost_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!(wr_en_i && addr_i == HPC_ADDR_BOOST) |=> $stable(port2_drive_current_sel_o))
		else $error("port two drive code moved");

	boost_p1_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!(wr_en_i && addr_i == HPC_ADDR_BOOST) |=> $stable(port1_drive_current_sel_o))
		else $error("port one drive code moved");

	swap_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		wr_en_i && addr_i == HPC_ADDR_SWAP |=> data_pin_swap_o == $past(wdata_i[3:1]))
		else $error("swap output wrong");

	swap_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!(wr_en_i && addr_i == HPC_ADDR_SWAP) |=> $stable(data_pin_swap_o))
		else $error("swap output moved");

	swap_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		swap_wr_s |=> swap == ($past(wdata_i) & HPC_MASK_SWAP))
		else $error("swap register wrong");

	swap_resv_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		swap[0] == 1'b0 && swap[7:4] == 4'h0)
		else $error("swap reserved bit set");

	rd_boost_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!wr_en_i && addr_i == HPC_ADDR_BOOST |=> rdata_o == boost)
		else $error("boost readback wrong");

	rd_swap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!wr_en_i && addr_i == HPC_ADDR_SWAP |=> rdata_o == swap)
		else $error("swap readback wrong");

	// Unmapped addresses read as zero so software sees no stale byte
	rd_unmapped_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		addr_i != HPC_ADDR_BOOST && addr_i != HPC_ADDR_SWAP && addr_i != HPC_ADDR_REMAP
		|=> rdata_o == 8'h00)
		else $error("unmapped read not zero");

	remap_readback_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_s ##1 remap_rd_s |=> rdata_o == remap)
		else $error("remap readback wrong");

	map_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!remap_mode_enable_i |=> port1_logical_o == 4'h1 && port2_logical_o == 4'h2)
		else $error("default numbering lost");

	map_on_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_mode_enable_i && !wr_en_i |=> port2_logical_o == remap[7:4])
		else $error("port two mapping wrong");

	map_p1_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_mode_enable_i && !wr_en_i |=> port1_logical_o == remap[3:0])
		else $error("port one mapping wrong");

	// A write in remap mode reaches the core on the same edge it lands
	map_wr_p2_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_on_s |=> port2_logical_o == remap[7:4])
		else $error("port two mapping late");

	map_wr_p1_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		remap_wr_on_s |=> port1_logical_o == remap[3:0])
		else $error("port one mapping late");

	map_range_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		port1_logical_o <= HPC_MAP_MAX && port2_logical_o <= HPC_MAP_MAX)
		else $error("reserved port number seen");

	count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		port_count_o == 2'h3)
		else $error("port count wrong");
endmodule

// ### dv/hpc_cpu.sv
// Configuring processor model for the register port
`timescale 1ns/100ps
module hpc_cpu (
	input wire logic mclk_i,
	output logic wr_en_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic mode_o
);
	initial {wr_en_o, addr_o, wdata_o, mode_o} = '0;
	// Strobe held across the taking edge; stale data is not left on the bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i) #1 {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
		@(posedge mclk_i) #1 wr_en_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic sel(input logic [7:0] a, input logic m);
		@(posedge mclk_i) #1 {addr_o, mode_o} = {a, m};
	endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the port configuration registers
`timescale 1ns/100ps
module tb;
	logic mclk_i = 0, rst_n_i = 0, we, md;
	logic [7:0] ad, wd, rd_o, b, s, r;
	logic [2:0] p1, p2, sw;
	logic [3:0] l1, l2;
	logic [1:0] cn;
	logic [26:0] q[$];
	int miscompares = 0, tests_run = 0, cyc = 0;
	event look;
	initial forever #25 mclk_i = ~mclk_i;
	hpc_cpu hpc_cpu_i (.mclk_i(mclk_i), .wr_en_o(we), .addr_o(ad), .wdata_o(wd), .mode_o(md));
	hpc_regs hpc_regs_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_en_i(we), .addr_i(ad),
		.wdata_i(wd), .rdata_o(rd_o), .remap_mode_enable_i(md), .port1_drive_current_sel_o(p1),
		.port2_drive_current_sel_o(p2), .data_pin_swap_o(sw), .port1_logical_o(l1),
		.port2_logical_o(l2), .port_count_o(cn));
	function automatic logic [3:0] fx(input logic [3:0] n);
		return n > 4'h3 ? 4'h0 : n;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		hpc_cpu_i.wr(a, d);
		if (a == 8'hF8) b = d & 8'h77;
		if (a == 8'hFA) s = d & 8'h0E;
		if (a == 8'hFB) r = {fx(d[7:4]), fx(d[3:0])};
	endtask
	task automatic chk(input logic [7:0] a, input logic m);
		logic [7:0] e;
		hpc_cpu_i.sel(a, m);
		@(posedge mclk_i) #1;
		e = a == 8'hF8 ? b : a == 8'hFA ? s : a == 8'hFB ? r : 8'h00;
		q.push_back({e, p2x(b), b[2:0], s[3:1], m ? r[3:0] : 4'h1, m ? r[7:4] : 4'h2, 2'h3});
		->look;
	endtask
	function automatic logic [2:0] p2x(input logic [7:0] v);
		return v[6:4];
	endfunction
	task automatic rst(input int n);
		@(posedge mclk_i) #1 rst_n_i = 0;
		repeat (n) @(posedge mclk_i);
		#1 rst_n_i = 1;
		{b, s, r} = {8'h00, 8'h00, 8'h21};
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(look) begin
		logic [26:0] e;
		e = q.pop_front();
		tests_run++;
		if (e !== {rd_o, p2, p1, sw, l1, l2, cn}) begin
			miscompares++;
			$display("MISMATCH outputs expected %h seen %h", e, {rd_o, p2, p1, sw, l1, l2, cn});
		end
	end
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			stop_test();
		end
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(55611));
		rst(6);
		for (int i = 0; i < 4; i++) chk(8'hF8 + i[7:0], i[0]);
		$display("Test reset values done");
		for (int k = 0; k < 16; k++) begin
			wr(8'hF8, {k[3:0], k[3:0]});
			wr(8'hFB, {k[3:0], ~k[3:0]});
			chk(8'hFB, 1'b1);
		end
		$display("Test code sweep done");
		wr(8'hFB, 8'h12);
		chk(8'hFB, 1'b0);
		for (int i = 0; i < 40; i++) begin
			wr(8'hF8 + 8'($urandom_range(0, 4)), 8'($urandom()));
			chk(8'($urandom_range(248, 252)), 1'($urandom()));
		end
		$display("Test random writes done");
		wr(8'hFA, 8'hFF);
		rst(1);
		chk(8'hFA, 1'b1);
		$display("Test mid-run reset done");
		stop_test();
	end
endmodule
